/* File: burst_sram_device.sv */
`timescale 1ns/1ps
// How it works
// - separate read and write ports, fully concurrent
// - both ports move data on both clock edges
// - each address holds a four-word burst
// - act only on rising edges of both clocks
// - shared address bus, read/write on alternate K
// - first read word two input cycles later
// - echo clock pair launched with read data
// - read and write each have own select
// - writes commit internally, no pulse timing needed
// - reads see latest write, even still pending
// - every input captured in a register first
// - every data output launched from a register
// - words every edge, no read/write turnaround gap
// - word width is 18 or 36 bits
// - boundary scan test access port provided
module burst_sram_device
    import burst_sram_pkg::*;
#(
    parameter int WORD_W = WORD_W_NARROW,
    parameter int ADDR_W = ADDR_W_NARROW
) (
    input wire logic clk,
    input wire logic rst_n,
    burst_sram_if.dev bus
);

    localparam int DEPTH = 1 << ADDR_W;

    // ****************************************
    // elaboration checks
    // ****************************************
    if (!(WORD_W == WORD_W_NARROW || WORD_W == WORD_W_WIDE)) begin : g_word_chk
        $error("word width must be 18 or 36");
    end
    if (ADDR_W < 1 || ADDR_W > 24) begin : g_addr_chk
        $error("address width out of range");
    end

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic half;
        logic rd_pend;
        logic [ADDR_W-1:0] rd_addr;
        logic out_act;
        logic out_hit;
        logic [ADDR_W-1:0] out_addr;
        logic wr_act;
        logic commit;
        logic [ADDR_W-1:0] wr_addr;
        logic [BURST_LEN-1:0][WORD_W-1:0] wbuf;
        logic [WORD_W-1:0] q;
        logic rto;
        logic rto_n;
        logic [1:0] tck_sync;
        logic [1:0] tms_sync;
        logic [1:0] tdi_sync;
        logic tck_last;
        tap_state_e tap;
        logic [TAP_IR_W-1:0] ir;
        logic byp;
        logic tdo;
        logic tdo_oe;
    } dev_state_s;

    dev_state_s s;
    dev_state_s next_s;
    logic [BURST_LEN-1:0][WORD_W-1:0] mem [0:DEPTH-1];
    logic [1:0] slot;
    logic [1:0] widx;
    logic tck_rise;
    logic tck_fall;

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        next_s = s;
        // each clk edge is one rising edge: K when k is high, K# otherwise;
        // the falling edges of the pair never reach this logic
        slot = {s.half, ~bus.k};
        widx = slot - SLOT_WRITE;
        tck_rise = s.tck_sync[1] & ~s.tck_last;
        tck_fall = ~s.tck_sync[1] & s.tck_last;

        // the alternate-K marker advances on every K# edge
        if (!bus.k) begin
            next_s.half = ~s.half;
        end

        // read address: sampled only on the first K of the cycle
        if (slot == SLOT_READ) begin
            next_s.rd_pend = ~bus.rd_sel_n;
            if (!bus.rd_sel_n) begin
                next_s.rd_addr = bus.addr;
            end
        end

        // hand the read to the output stage one edge before word 0 leaves;
        // a hit on the write captured this cycle is frozen here so that a
        // later write cannot change the burst mid-flight
        if (slot == SLOT_LAST) begin
            next_s.out_act = s.rd_pend;
            next_s.out_addr = s.rd_addr;
            next_s.out_hit = s.wr_act && (s.wr_addr == s.rd_addr);
        end

        // read burst: one word on each of the four following edges
        if (s.out_act) begin
            next_s.q = s.out_hit ? s.wbuf[slot] : mem[s.out_addr][slot];
        end else begin
            next_s.q = '0;
        end
        next_s.rto = bus.k;
        next_s.rto_n = ~bus.k;

        // write: address on the second K, data from that edge onward
        next_s.commit = 1'b0;
        if (slot == SLOT_WRITE) begin
            next_s.wr_act = ~bus.wr_sel_n;
            if (!bus.wr_sel_n) begin
                next_s.wr_addr = bus.addr;
                next_s.wbuf[0] = bus.d;
            end
        end else if (s.wr_act) begin
            next_s.wbuf[widx] = bus.d;
            if (widx == 2'(BURST_LEN - 1)) begin
                next_s.wr_act = 1'b0;
                next_s.commit = 1'b1;
            end
        end

        // boundary scan, clocked by the synchronised test clock
        next_s.tck_sync = {s.tck_sync[0], bus.tck};
        next_s.tms_sync = {s.tms_sync[0], bus.tms};
        next_s.tdi_sync = {s.tdi_sync[0], bus.tdi};
        next_s.tck_last = s.tck_sync[1];
        if (tck_rise) begin
            next_s.tap = tap_next(s.tap, s.tms_sync[1]);
            case (s.tap)
                TAP_CAP_IR: begin
                    next_s.ir = TAP_IR_CAPTURE;
                end
                TAP_SHIFT_IR: begin
                    next_s.ir = {s.tdi_sync[1], s.ir[TAP_IR_W-1:1]};
                end
                TAP_CAP_DR: begin
                    next_s.byp = 1'b0;
                end
                TAP_SHIFT_DR: begin
                    next_s.byp = s.tdi_sync[1];
                end
                default: begin
                end
            endcase
        end
        // the test data output changes on the falling test clock edge
        if (tck_fall) begin
            next_s.tdo = (s.tap == TAP_SHIFT_IR) ? s.ir[0] : s.byp;
            next_s.tdo_oe = (s.tap == TAP_SHIFT_IR) || (s.tap == TAP_SHIFT_DR);
        end
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s <= '0;
            s.tap <= TAP_RESET;
            // the reset level of k is taken as the K# edge that closes a cycle
            s.half <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // array is not reset; the commit lands one edge after the last word,
    // so a read in between is served from the write buffer instead
    always_ff @(posedge clk) begin
        if (s.commit) begin
            mem[s.wr_addr] <= s.wbuf;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign bus.q = s.q;
    assign bus.returned_timing_output = s.rto;
    assign bus.returned_timing_output_n = s.rto_n;
    assign bus.tdo = s.tdo;
    assign bus.tdo_oe = s.tdo_oe;

endmodule

/* File: burst_sram_pkg.sv */
// ****************************************
// shared constants
// ****************************************
package burst_sram_pkg;

    // word widths of the two build options
    localparam int WORD_W_NARROW = 18;
    localparam int WORD_W_WIDE = 36;
    // burst locations: 4M x 18 words is 1M four-word locations
    localparam int ADDR_W_NARROW = 20;
    localparam int BURST_LEN = 4;

    // fastest input clock the interface is rated for, and our system clock
    localparam int K_MAX_MHZ = 250;
    localparam int CLK_MHZ = 40;
    // one input-clock period spans two system clock edges (K rise, K# rise)
    localparam int EDGES_PER_K = 2;
    localparam real READ_LATENCY_K = 2.0;
    localparam int READ_LATENCY_EDGES = int'(READ_LATENCY_K * EDGES_PER_K);

    // slot of the four-edge address cycle: {alternate K, K# edge}
    localparam logic [1:0] SLOT_READ = 2'h0;
    localparam logic [1:0] SLOT_WRITE = 2'h2;
    localparam logic [1:0] SLOT_LAST = 2'h3;

    // boundary scan
    localparam int TAP_IR_W = 3;
    localparam logic [TAP_IR_W-1:0] TAP_IR_CAPTURE = 3'h1;

    typedef enum logic [3:0] {
        TAP_RESET, TAP_IDLE,
        TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR,
        TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR,
        TAP_SEL_IR, TAP_CAP_IR, TAP_SHIFT_IR, TAP_EXIT1_IR,
        TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
    } tap_state_e;

    function automatic tap_state_e tap_next(input tap_state_e st, input logic tms);
        case (st)
            TAP_RESET: tap_next = tms ? TAP_RESET : TAP_IDLE;
            TAP_IDLE: tap_next = tms ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_DR: tap_next = tms ? TAP_SEL_IR : TAP_CAP_DR;
            TAP_CAP_DR: tap_next = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_SHIFT_DR: tap_next = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_EXIT1_DR: tap_next = tms ? TAP_UPD_DR : TAP_PAUSE_DR;
            TAP_PAUSE_DR: tap_next = tms ? TAP_EXIT2_DR : TAP_PAUSE_DR;
            TAP_EXIT2_DR: tap_next = tms ? TAP_UPD_DR : TAP_SHIFT_DR;
            TAP_UPD_DR: tap_next = tms ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_IR: tap_next = tms ? TAP_RESET : TAP_CAP_IR;
            TAP_CAP_IR: tap_next = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_SHIFT_IR: tap_next = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_EXIT1_IR: tap_next = tms ? TAP_UPD_IR : TAP_PAUSE_IR;
            TAP_PAUSE_IR: tap_next = tms ? TAP_EXIT2_IR : TAP_PAUSE_IR;
            TAP_EXIT2_IR: tap_next = tms ? TAP_UPD_IR : TAP_SHIFT_IR;
            default: tap_next = tms ? TAP_SEL_DR : TAP_IDLE;
        endcase
    endfunction

endpackage

/* File: burst_sram_if.sv */
`timescale 1ns/1ps
// ****************************************
// pins between memory and controller
// ****************************************
interface burst_sram_if
    import burst_sram_pkg::*;
#(
    parameter int WORD_W = WORD_W_NARROW,
    parameter int ADDR_W = ADDR_W_NARROW
);
    logic k;
    logic k_n;
    logic [ADDR_W-1:0] addr;
    logic rd_sel_n;
    logic wr_sel_n;
    logic [WORD_W-1:0] d;
    logic [WORD_W-1:0] q;
    logic returned_timing_output;
    logic returned_timing_output_n;
    logic tck;
    logic tms;
    logic tdi;
    logic tdo;
    logic tdo_oe;

    modport dev (
        input k, k_n, addr, rd_sel_n, wr_sel_n, d, tck, tms, tdi,
        output q, returned_timing_output, returned_timing_output_n, tdo, tdo_oe
    );

    modport ctl (
        output k, k_n, addr, rd_sel_n, wr_sel_n, d, tck, tms, tdi,
        input q, returned_timing_output, returned_timing_output_n, tdo, tdo_oe
    );
endinterface

/* File: burst_sram_controller.sv */
`timescale 1ns/1ps
module burst_sram_controller
    import burst_sram_pkg::*;
#(
    parameter int WORD_W = WORD_W_NARROW,
    parameter int ADDR_W = ADDR_W_NARROW,
    parameter int BUF_DEPTH = 2
) (
    input wire logic clk,
    input wire logic rst_n,
    burst_sram_if.ctl bus,
    input wire logic rd_cmd_valid,
    input wire logic [ADDR_W-1:0] rd_cmd_addr,
    output logic rd_cmd_ready,
    input wire logic wr_cmd_valid,
    input wire logic [ADDR_W-1:0] wr_cmd_addr,
    input wire logic [BURST_LEN*WORD_W-1:0] wr_cmd_data,
    output logic wr_cmd_ready,
    output logic rd_data_valid,
    output logic [BURST_LEN*WORD_W-1:0] rd_data,
    input wire logic rd_data_ready,
    input wire logic scan_tck,
    input wire logic scan_tms,
    input wire logic scan_tdi,
    output logic scan_tdo
);

    localparam int CNT_W = $clog2(BUF_DEPTH + 1);
    localparam int PIPE = READ_LATENCY_EDGES + BURST_LEN + 1;

    if (BUF_DEPTH < 1) begin : g_depth_chk
        $error("buffer depth must be at least one");
    end
    if (!(WORD_W == WORD_W_NARROW || WORD_W == WORD_W_WIDE)) begin : g_word_chk
        $error("word width must be 18 or 36");
    end

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic [1:0] slot;
        logic k;
        logic k_n;
        logic [ADDR_W-1:0] addr;
        logic rd_sel_n;
        logic wr_sel_n;
        logic [WORD_W-1:0] d;
        logic [BURST_LEN-1:0][WORD_W-1:0] wdata;
        logic rd_cmd_ready;
        logic wr_cmd_ready;
        logic [CNT_W-1:0] credits;
        logic [PIPE-1:0] rpipe;
        logic [BURST_LEN-2:0][WORD_W-1:0] rcol;
        logic [BUF_DEPTH-1:0][BURST_LEN*WORD_W-1:0] fifo;
        logic [CNT_W-1:0] cnt;
        logic rd_data_valid;
        logic tck;
        logic tms;
        logic tdi;
        logic scan_tdo;
    } ctl_state_s;

    ctl_state_s s;
    ctl_state_s next_s;
    logic issue_rd;
    logic issue_wr;
    logic push;
    logic pop;

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        next_s = s;
        next_s.slot = s.slot + 2'h1;
        next_s.k = ~next_s.slot[0];
        next_s.k_n = next_s.slot[0];
        next_s.rd_sel_n = 1'b1;
        next_s.wr_sel_n = 1'b1;

        // commands are offered only on the edge before their own slot
        issue_rd = s.rd_cmd_ready && rd_cmd_valid;
        issue_wr = s.wr_cmd_ready && wr_cmd_valid;
        if (issue_rd) begin
            next_s.addr = rd_cmd_addr;
            next_s.rd_sel_n = 1'b0;
        end
        if (issue_wr) begin
            next_s.addr = wr_cmd_addr;
            next_s.wr_sel_n = 1'b0;
            next_s.wdata = wr_cmd_data;
            next_s.d = wr_cmd_data[WORD_W-1:0];
        end else begin
            next_s.d = s.wdata[next_s.slot - SLOT_WRITE];
        end

        // read words return a fixed number of edges after the select
        next_s.rpipe = {s.rpipe[PIPE-2:0], issue_rd};
        for (int i = 0; i < BURST_LEN - 1; i++) begin
            if (s.rpipe[READ_LATENCY_EDGES + 1 + i]) begin
                next_s.rcol[i] = bus.q;
            end
        end
        push = s.rpipe[PIPE-1];
        pop = s.rd_data_valid && rd_data_ready;

        // shift buffer: entry 0 is the head and feeds the output directly
        if (pop) begin
            for (int i = 0; i < BUF_DEPTH - 1; i++) begin
                next_s.fifo[i] = s.fifo[i + 1];
            end
        end
        if (push) begin
            next_s.fifo[pop ? CNT_W'(s.cnt - 1'b1) : s.cnt] = {bus.q, s.rcol};
        end
        next_s.cnt = s.cnt + CNT_W'(push) - CNT_W'(pop);
        next_s.rd_data_valid = (next_s.cnt != '0);

        // a read is issued only when its burst is sure of a buffer place,
        // so a stalled consumer holds off new reads instead of losing words
        next_s.credits = s.credits + CNT_W'(pop) - CNT_W'(issue_rd);
        next_s.rd_cmd_ready = (next_s.slot == SLOT_LAST) && (next_s.credits != '0);
        next_s.wr_cmd_ready = (next_s.slot == SLOT_WRITE - 2'h1);

        next_s.tck = scan_tck;
        next_s.tms = scan_tms;
        next_s.tdi = scan_tdi;
        next_s.scan_tdo = bus.tdo;
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s <= '0;
            s.slot <= SLOT_LAST;
            s.k_n <= 1'b1;
            s.rd_sel_n <= 1'b1;
            s.wr_sel_n <= 1'b1;
            s.credits <= CNT_W'(BUF_DEPTH);
            s.tms <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign bus.k = s.k;
    assign bus.k_n = s.k_n;
    assign bus.addr = s.addr;
    assign bus.rd_sel_n = s.rd_sel_n;
    assign bus.wr_sel_n = s.wr_sel_n;
    assign bus.d = s.d;
    assign bus.tck = s.tck;
    assign bus.tms = s.tms;
    assign bus.tdi = s.tdi;
    assign rd_cmd_ready = s.rd_cmd_ready;
    assign wr_cmd_ready = s.wr_cmd_ready;
    assign rd_data_valid = s.rd_data_valid;
    assign rd_data = s.fifo[0];
    assign scan_tdo = s.scan_tdo;

endmodule

/* File: burst_sram_sva.sv */
`timescale 1ns/1ps
// ****************************************
// link checks between the two ends
// ****************************************
module burst_sram_sva #(
    parameter int WORD_W = 18
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic k,
    input wire logic k_n,
    input wire logic rd_sel_n,
    input wire logic wr_sel_n,
    input wire logic [WORD_W-1:0] q,
    input wire logic returned_timing_output,
    input wire logic returned_timing_output_n,
    input wire logic tdo_oe
);
    // read captures seen on past edges; q may only be busy 4..7 edges after one
    logic [7:0] rd_hist;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rd_hist <= 8'h00;
        end else begin
            rd_hist <= {rd_hist[6:0], !rd_sel_n && k};
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_k_toggle;
        $past(rst_n) |-> k != $past(k);
    endproperty
    a_k_toggle: assert property (p_k_toggle)
        else $error("k did not toggle");

    property p_k_pair;
        k_n == !k;
    endproperty
    a_k_pair: assert property (p_k_pair)
        else $error("k_n is not the complement of k");

    property p_k_start;
        $rose(rst_n) |=> k;
    endproperty
    a_k_start: assert property (p_k_start)
        else $error("first slot after reset is not a k edge");

    property p_echo;
        $past(rst_n) |-> returned_timing_output == $past(k)
            && returned_timing_output_n == !$past(k);
    endproperty
    a_echo: assert property (p_echo)
        else $error("echo pair does not follow k");

    property p_rd_slot;
        !rd_sel_n |-> k && wr_sel_n ##1 rd_sel_n && wr_sel_n ##1 rd_sel_n
            ##1 rd_sel_n && wr_sel_n;
    endproperty
    a_rd_slot: assert property (p_rd_slot)
        else $error("read select outside its slot");

    property p_wr_slot;
        !wr_sel_n |-> k ##1 wr_sel_n [*3];
    endproperty
    a_wr_slot: assert property (p_wr_slot)
        else $error("write select outside its slot");

    property p_q_idle;
        q != '0 |-> |rd_hist[7:4];
    endproperty
    a_q_idle: assert property (p_q_idle)
        else $error("read data outside its burst window");

    property p_tdo_oe_rst;
        !$past(rst_n) |-> !tdo_oe;
    endproperty
    a_tdo_oe_rst: assert property (p_tdo_oe_rst)
        else $error("scan output enabled right after reset");
endmodule

/* File: quad_rate_burst_sram_interface_test.sv */
`timescale 1ns/1ps
module quad_rate_burst_sram_interface_test;
    import burst_sram_pkg::*;
    localparam int WW = WORD_W_NARROW;
    localparam int AW = 6;
    localparam int BW = BURST_LEN * WW;
    // negedges after the taking edge: word 0 shows after drive, capture and latency
    localparam int Q0 = 2 + READ_LATENCY_EDGES;
    // the last word is captured one edge later, so the result is whole here
    localparam int LAT = Q0 + BURST_LEN;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic rd_cmd_valid = 1'b0;
    logic [AW-1:0] rd_cmd_addr = '0;
    logic rd_cmd_ready;
    logic wr_cmd_valid = 1'b0;
    logic [AW-1:0] wr_cmd_addr = '0;
    logic [BW-1:0] wr_cmd_data = '0;
    logic wr_cmd_ready;
    logic rd_data_valid;
    logic [BW-1:0] rd_data;
    logic rd_data_ready = 1'b1;
    // tms high holds the test port in reset until the scan test
    logic scan_tck = 1'b0;
    logic scan_tms = 1'b1;
    logic scan_tdi = 1'b0;
    logic scan_tdo;
    int num_errors = 0;
    int checks = 0;

    burst_sram_if #(.WORD_W(WW), .ADDR_W(AW)) bus ();
    burst_sram_device #(.WORD_W(WW), .ADDR_W(AW)) i_burst_sram_device (
        .clk(clk), .rst_n(rst_n), .bus(bus));
    burst_sram_controller #(.WORD_W(WW), .ADDR_W(AW)) i_burst_sram_controller (
        .clk(clk), .rst_n(rst_n), .bus(bus),
        .rd_cmd_valid(rd_cmd_valid), .rd_cmd_addr(rd_cmd_addr), .rd_cmd_ready(rd_cmd_ready),
        .wr_cmd_valid(wr_cmd_valid), .wr_cmd_addr(wr_cmd_addr), .wr_cmd_data(wr_cmd_data),
        .wr_cmd_ready(wr_cmd_ready), .rd_data_valid(rd_data_valid), .rd_data(rd_data),
        .rd_data_ready(rd_data_ready), .scan_tck(scan_tck), .scan_tms(scan_tms),
        .scan_tdi(scan_tdi), .scan_tdo(scan_tdo));
    burst_sram_sva #(.WORD_W(WW)) chk (
        .clk(clk), .rst_n(rst_n), .k(bus.k), .k_n(bus.k_n),
        .rd_sel_n(bus.rd_sel_n), .wr_sel_n(bus.wr_sel_n), .q(bus.q),
        .returned_timing_output(bus.returned_timing_output),
        .returned_timing_output_n(bus.returned_timing_output_n), .tdo_oe(bus.tdo_oe));

    initial begin
        forever #12.5 clk = ~clk;
    end

    // ****************************************
    // report and compare
    // ****************************************
    task automatic finish_test();
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic err(input string msg);
        $display("[ERR] %0t %s", $time, msg);
        num_errors++;
    endtask

    task automatic timeout(input string msg);
        err(msg);
        finish_test();
    endtask

    task automatic check_data(input logic [BW-1:0] got, input logic [BW-1:0] exp,
                              input string what);
        checks++;
        if (got !== exp) err(what);
    endtask

    task automatic check_bit(input logic got, input logic exp, input string what);
        checks++;
        if (got !== exp) err(what);
    endtask

    // words kept nonzero and distinct so a swapped or dropped word shows
    function automatic logic [BW-1:0] pat(input int a, input int s);
        for (int i = 0; i < BURST_LEN; i++) pat[i*WW +: WW] = WW'(s * 256 + a * 4 + i + 1);
    endfunction

    // ****************************************
    // user side drivers
    // ****************************************
    task automatic do_write(input int a, input int s);
        int n;
        @(negedge clk);
        wr_cmd_valid = 1'b1;
        wr_cmd_addr = AW'(a);
        wr_cmd_data = pat(a, s);
        for (n = 0; wr_cmd_ready !== 1'b1; n++) begin
            if (n > 200) timeout("write not taken");
            @(negedge clk);
        end
        @(negedge clk);
        wr_cmd_valid = 1'b0;
    endtask

    task automatic do_read(input int a);
        int n;
        @(negedge clk);
        rd_cmd_valid = 1'b1;
        rd_cmd_addr = AW'(a);
        for (n = 0; rd_cmd_ready !== 1'b1; n++) begin
            if (n > 200) timeout("read not taken");
            @(negedge clk);
        end
        @(negedge clk);
        rd_cmd_valid = 1'b0;
    endtask

    task automatic get_read(input int a, input int s);
        int n;
        for (n = 0; rd_data_valid !== 1'b1; n++) begin
            if (n > 200) timeout("no read data");
            @(negedge clk);
        end
        check_data(rd_data, pat(a, s), "read data");
        @(negedge clk);
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic test_basic();
        do_write(0, 1);
        do_write(63, 2);
        do_read(0);
        get_read(0, 1);
        do_read(63);
        get_read(63, 2);
        $display("test_basic done");
    endtask

    task automatic test_coherent();
        do_write(0, 3);
        do_read(0);
        get_read(0, 3);
        // a write taken just after a read of the same address joins its cycle,
        // so the burst is served from the write buffer with the new words
        do_read(0);
        do_write(0, 5);
        get_read(0, 5);
        $display("test_coherent done");
    endtask

    task automatic test_latency();
        int n;
        logic [BW-1:0] exp;
        exp = pat(63, 2);
        do_read(63);
        for (n = 1; rd_data_valid !== 1'b1 && n < 40; n++) begin
            if (n >= Q0 && n < Q0 + BURST_LEN) begin
                check_data(BW'(bus.q), BW'(exp[(n-Q0)*WW +: WW]), "q word");
            end
            @(negedge clk);
        end
        check_bit(n == LAT, 1'b1, "read latency");
        get_read(63, 2);
        $display("test_latency done");
    endtask

    task automatic test_concurrent();
        fork
            for (int i = 10; i < 13; i++) do_write(i, 4);
            begin
                do_read(0);
                do_read(63);
            end
            begin
                get_read(0, 5);
                get_read(63, 2);
            end
        join
        fork
            for (int i = 10; i < 13; i++) do_read(i);
            for (int i = 10; i < 13; i++) get_read(i, 4);
        join
        $display("test_concurrent done");
    endtask

    task automatic test_stall();
        logic seen;
        seen = 1'b0;
        @(negedge clk);
        rd_data_ready = 1'b0;
        do_read(10);
        do_read(11);
        fork
            do_read(12);
            begin
                repeat (40) begin
                    @(negedge clk);
                    if (rd_cmd_ready === 1'b1) seen = 1'b1;
                end
                check_bit(seen, 1'b0, "read taken with buffer full");
                rd_data_ready = 1'b1;
                get_read(10, 4);
                get_read(11, 4);
                get_read(12, 4);
            end
        join
        $display("test_stall done");
    endtask

    // one slow test clock period; slow enough for both synchronisers and the
    // returned output register, so tdo is taken well after the falling edge
    task automatic scan_step(input logic ms, input logic di, output logic tdo_v);
        scan_tms = ms;
        scan_tdi = di;
        repeat (8) @(negedge clk);
        scan_tck = 1'b1;
        repeat (8) @(negedge clk);
        scan_tck = 1'b0;
        repeat (8) @(negedge clk);
        tdo_v = scan_tdo;
    endtask

    task automatic test_scan();
        logic tdo_v;
        scan_step(1'b0, 1'b0, tdo_v);
        scan_step(1'b1, 1'b0, tdo_v);
        scan_step(1'b0, 1'b0, tdo_v);
        scan_step(1'b0, 1'b0, tdo_v);
        check_bit(tdo_v, 1'b0, "captured bypass bit");
        check_bit(bus.tdo_oe, 1'b1, "scan output not enabled");
        scan_step(1'b0, 1'b1, tdo_v);
        check_bit(tdo_v, 1'b1, "bypass bit not shifted");
        scan_step(1'b1, 1'b0, tdo_v);
        check_bit(tdo_v, 1'b0, "last bypass bit not shifted");
        check_bit(bus.tdo_oe, 1'b0, "scan output left enabled");
        $display("test_scan done");
    endtask

    initial begin
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        test_basic();
        test_coherent();
        test_latency();
        test_concurrent();
        test_stall();
        test_scan();
        finish_test();
    end
endmodule
